// ==== src/irq_remap_steering.sv ====
// legacy interrupt steering registers behind an apb slave
`timescale 1ns/10ps
// Summary of operation
// - bit 7 of each steering register turns steering on when clear, off when set (reset).
// - codes 0011 to 0111 steer the source to legacy lines 3 to 7.
// - codes 1001 to 1100 steer to lines 9 to 12, 1110 to line 14, 1111 to line 15.
// - the power-event source has its own register of the same layout, bits 6 to 4 spare.
module irq_remap_steering
  import irq_route_pkg::*;
#(
  parameter int ADDR_W = 12 // apb address width
)
(
  input wire logic pclk, // bus clock, 200 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction, high for write
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic disk_primary_interrupt, // primary disk channel interrupt
  input wire logic disk_secondary_interrupt, // secondary disk channel interrupt
  input wire logic usb_host_interrupt, // usb host interrupt
  input wire logic power_event_interrupt, // power-event interrupt
  output logic [irq_route_pkg::NUM_LINES-1:0] legacy_interrupt_line // legacy lines, high active
);
  import irq_route_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_SOURCES-1:0][7:0] route;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [NUM_LINES-1:0] lines;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic [NUM_SOURCES-1:0] src;
  logic [NUM_SOURCES-1:0][NUM_LINES-1:0] hit;
  logic [NUM_LINES-1:0] hit_any;
  logic setup;
  logic access;
  logic [1:0] sel_idx;
  logic sel_ok;

  // ---------------------------------------------------------------
  // source selection and per-source decoders
  // ---------------------------------------------------------------
  // disk channel chosen by bit 4 of its own register
  assign src[SRC_DISK] = cur.route[SRC_DISK][CHAN_SEL_BIT] ? disk_secondary_interrupt
                                                           : disk_primary_interrupt;
  assign src[SRC_USB] = usb_host_interrupt;
  assign src[SRC_POWER] = power_event_interrupt;

  generate
    for (genvar i = 0; i < NUM_SOURCES; i++)
    begin : g_src
      route_decode u_dec (
        .route_cfg(cur.route[i]),
        .source(src[i]),
        .line_hit(hit[i])
      );
    end
  endgenerate

  // two sources on one line share it, as a wired level would
  always_comb
  begin
    hit_any = '0;
    for (int i = 0; i < NUM_SOURCES; i++)
    begin
      hit_any = hit_any | hit[i];
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // full-address match, so stray low bits count as unmapped
  always_comb
  begin
    sel_ok = 1'b1;
    sel_idx = 2'(SRC_DISK);
    case (paddr[11:0])
      DISK_ROUTE_ADDR: sel_idx = 2'(SRC_DISK);
      USB_ROUTE_ADDR: sel_idx = 2'(SRC_USB);
      POWER_ROUTE_ADDR: sel_idx = 2'(SRC_POWER);
      default: sel_ok = 1'b0;
    endcase
  end

  assign setup = psel && !penable;
  assign access = psel && penable && cur.ready;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // read data and ready are prepared in the setup cycle so every
  // access answers in exactly one cycle, straight from flops
  always_comb
  begin
    next_cur = cur;
    next_cur.ready = setup;
    next_cur.err = setup && !sel_ok;
    next_cur.rdata = '0;
    if (setup && sel_ok && !pwrite)
    begin
      next_cur.rdata = {24'h000000, cur.route[sel_idx]};
    end
    // reserved bits are plain storage, written and read back as is
    if (access && pwrite && sel_ok && pstrb[0])
    begin
      next_cur.route[sel_idx] = pwdata[7:0];
    end
    next_cur.lines = hit_any;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur.route <= {NUM_SOURCES{ROUTE_RESET}};
      cur.rdata <= '0;
      cur.ready <= 1'b0;
      cur.err <= 1'b0;
      cur.lines <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign prdata = cur.rdata;
  assign pready = cur.ready;
  assign pslverr = cur.err;
  assign legacy_interrupt_line = cur.lines;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [3:0] disk_code;
  logic [3:0] usb_code;
  logic [3:0] pwr_code;
  logic others_off_usb;
  logic others_off_disk;
  logic others_off_pwr;
  assign disk_code = cur.route[SRC_DISK][3:0];
  assign usb_code = cur.route[SRC_USB][3:0];
  assign pwr_code = cur.route[SRC_POWER][3:0];
  assign others_off_usb = cur.route[SRC_DISK][7] && cur.route[SRC_POWER][7];
  assign others_off_disk = cur.route[SRC_USB][7] && cur.route[SRC_POWER][7];
  assign others_off_pwr = cur.route[SRC_DISK][7] && cur.route[SRC_USB][7];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_all_off_silent: assert property (
    (cur.route[0][7] && cur.route[1][7] && cur.route[2][7]) [*2] |=> legacy_interrupt_line == '0)
    else $error("line driven while every steering register is off");

  a_low_code_line: assert property (
    (others_off_usb && !cur.route[SRC_USB][7] && usb_host_interrupt
     && usb_code >= 4'h3 && usb_code <= 4'h7)
    |=> legacy_interrupt_line == (16'h0001 << $past(usb_code)))
    else $error("usb code 3 to 7 did not reach the matching line");

  a_high_code_line: assert property (
    (others_off_usb && !cur.route[SRC_USB][7] && usb_host_interrupt
     && ((usb_code >= 4'h9 && usb_code <= 4'hC) || usb_code >= 4'hE))
    |=> legacy_interrupt_line == (16'h0001 << $past(usb_code)))
    else $error("usb high code did not reach the matching line");

  a_reserved_silent: assert property (
    (others_off_pwr && !code_legal(pwr_code)) |=> legacy_interrupt_line == '0)
    else $error("reserved code drove a legacy line");

  a_power_route: assert property (
    (others_off_pwr && !cur.route[SRC_POWER][7] && code_legal(pwr_code)
     && power_event_interrupt) |=> legacy_interrupt_line[$past(pwr_code)])
    else $error("power-event source not steered");

  a_channel_pick: assert property (
    (others_off_disk && !cur.route[SRC_DISK][7] && code_legal(disk_code)
     && disk_primary_interrupt != disk_secondary_interrupt)
    |=> legacy_interrupt_line[$past(disk_code)] ==
        $past(cur.route[SRC_DISK][4] ? disk_secondary_interrupt : disk_primary_interrupt))
    else $error("disk channel select picked the wrong channel");

  a_apb_one_wait: assert property (
    setup |=> pready ##1 !pready)
    else $error("apb ready not a single pulse after setup");

  // a write must land in the register its address picked, all eight bits kept
  a_write_lands: assert property (
    (access && pwrite && sel_ok && pstrb[0])
    |=> cur.route[$past(sel_idx)] == $past(pwdata[7:0]))
    else $error("apb write did not reach its steering register");

  a_usb_off_silent: assert property (
    (others_off_usb && cur.route[SRC_USB][7]) |=> legacy_interrupt_line == '0)
    else $error("usb source drove a line while its steering was off");

  // an unmapped address answers with an error and no data
  a_unmapped_error: assert property (
    (setup && !sel_ok) |=> pready && pslverr && prdata == '0)
    else $error("unmapped address not refused");

  c_usb_steered: cover property (!cur.route[SRC_USB][7] && usb_host_interrupt ##1
    legacy_interrupt_line != '0);
  c_secondary_disk: cover property (cur.route[SRC_DISK][4] && !cur.route[SRC_DISK][7]);
  c_unmapped: cover property (pready && pslverr);
  c_reserved_code: cover property (!cur.route[SRC_POWER][7] && !code_legal(pwr_code)
    && power_event_interrupt);
endmodule

// ==== inc/irq_route_pkg.sv ====
// constants, field layout and helpers for the interrupt steering block
package irq_route_pkg;

  // ---------------------------------------------------------------
  // register indices as printed; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [11:0] DISK_ROUTE_IDX = 12'h061;
  localparam logic [11:0] USB_ROUTE_IDX = 12'h062;
  localparam logic [11:0] POWER_ROUTE_IDX = 12'h063;
  localparam logic [11:0] DISK_ROUTE_ADDR = 12'(DISK_ROUTE_IDX * 4);
  localparam logic [11:0] USB_ROUTE_ADDR = 12'(USB_ROUTE_IDX * 4);
  localparam logic [11:0] POWER_ROUTE_ADDR = 12'(POWER_ROUTE_IDX * 4);

  // ---------------------------------------------------------------
  // field layout and reset value
  // ---------------------------------------------------------------
  localparam logic [7:0] ROUTE_RESET = 8'h80;
  localparam int ROUTE_OFF_BIT = 7;
  localparam int CHAN_SEL_BIT = 4;
  localparam int CODE_LSB = 0;
  localparam int CODE_W = 4;
  localparam int NUM_SOURCES = 3;
  localparam int NUM_LINES = 16;
  localparam int SRC_DISK = 0;
  localparam int SRC_USB = 1;
  localparam int SRC_POWER = 2;

  // ---------------------------------------------------------------
  // line-select codes that name a real legacy line
  // ---------------------------------------------------------------
  function automatic logic code_legal(input logic [3:0] code);
    case (code)
      4'h0, 4'h1, 4'h2, 4'h8, 4'hD: code_legal = 1'b0;
      default: code_legal = 1'b1;
    endcase
  endfunction

endpackage

// ==== src/route_decode.sv ====
// steering decoder: one source onto one of sixteen legacy lines
`timescale 1ns/10ps
module route_decode
  import irq_route_pkg::*;
(
  input wire logic [7:0] route_cfg, // steering register of this source
  input wire logic source, // interrupt source level, high active
  output logic [irq_route_pkg::NUM_LINES-1:0] line_hit // one-hot line this source drives
);
  import irq_route_pkg::*;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // a set off bit or a reserved code drives nothing at all
  always_comb
  begin
    logic [CODE_W-1:0] code;
    code = route_cfg[CODE_LSB +: CODE_W];
    line_hit = '0;
    if (source && !route_cfg[ROUTE_OFF_BIT] && code_legal(code))
    begin
      line_hit[code] = 1'b1;
    end
  end
endmodule

// ==== src/dummy_unused_placeholder.sv ====
// intentionally empty
`timescale 1ns/10ps

// ==== test/irq_line_sink.sv ====
// interrupt controller model that latches the legacy line levels
`timescale 1ns/10ps
module irq_line_sink
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // reset, active low
  input wire logic [15:0] legacy_interrupt_line, // steered lines, high active
  output logic [15:0] seen // line levels taken at the last edge
);
  // level inputs with no glitch filter, so a one-cycle spike is seen too
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seen <= '0;
    else
      seen <= legacy_interrupt_line;
  end
endmodule

// ==== test/irq_remap_steering_bench.sv ====
// self-checking bench for the legacy interrupt steering block
`timescale 1ns/10ps
module irq_remap_steering_bench;
  import irq_route_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, err;
  logic [3:0] src = '0; // primary, secondary, usb, power
  logic [15:0] legacy_interrupt_line, seen;
  int errors = 0, compares = 0;
  always #2.5 pclk = ~pclk;
  irq_remap_steering i_irq_remap_steering (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .disk_primary_interrupt(src[0]), .disk_secondary_interrupt(src[1]),
    .usb_host_interrupt(src[2]), .power_event_interrupt(src[3]),
    .legacy_interrupt_line);
  irq_line_sink i_irq_line_sink (.pclk, .presetn, .legacy_interrupt_line, .seen);
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one apb transfer; waits for ready however long, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      @(posedge pclk);
    end
    chk("wait states", n, 0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // an idle edge keeps the next call from raising psel in this same step
    @(posedge pclk);
  endtask
  task automatic settle(input string name, input logic [15:0] exp);
    repeat (3) @(posedge pclk);
    chk(name, seen, exp);
  endtask
  task automatic give_verdict;
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // defaults read back and keep every source off the lines
  task automatic t_reset;
    src <= 4'hF;
    for (int s = 0; s < 3; s++)
    begin
      apb(1'b0, 12'(DISK_ROUTE_ADDR + 4 * s), 32'h0);
      chk("reset value", rd, 32'h80);
      chk("mapped error", err, 0);
    end
    settle("lines after reset", 16'h0);
    src <= 4'h0;
  endtask
  // every code on every source, reserved ones included to see no line
  task automatic t_codes;
    int b;
    logic [15:0] exp;
    for (int s = 0; s < 3; s++)
    begin
      b = (s == 0) ? 0 : s + 1;
      for (int c = 0; c < 16; c++)
      begin
        exp = (c inside {0, 1, 2, 8, 13}) ? 16'h0 : 16'h1 << c;
        apb(1'b1, 12'(DISK_ROUTE_ADDR + 4 * s), 32'(c));
        apb(1'b0, 12'(DISK_ROUTE_ADDR + 4 * s), 32'h0);
        chk("readback", rd, 32'(c));
        src[b] <= 1'b1;
        settle("steered line", exp);
        src[b] <= 1'b0;
        settle("line released", 16'h0);
      end
      // switched off again with a legal code, so the next source owns the lines alone
      apb(1'b1, 12'(DISK_ROUTE_ADDR + 4 * s), 32'h8F);
      src[b] <= 1'b1;
      settle("source switched off", 16'h0);
      src[b] <= 1'b0;
    end
  endtask
  // channel pick, disable bit and an unmapped address
  task automatic t_misc;
    apb(1'b1, DISK_ROUTE_ADDR, 32'h15);
    src <= 4'h1;
    settle("primary unpicked", 16'h0);
    src <= 4'h2;
    settle("secondary picked", 16'h0020);
    apb(1'b1, DISK_ROUTE_ADDR, 32'h95);
    settle("steering off", 16'h0);
    // a write with the low byte strobe clear must leave the register alone
    pstrb <= 4'hE;
    apb(1'b1, DISK_ROUTE_ADDR, 32'h03);
    pstrb <= 4'hF;
    apb(1'b0, DISK_ROUTE_ADDR, 32'h0);
    chk("strobe off ignored", rd, 32'h95);
    src <= 4'h0;
    apb(1'b0, 12'h190, 32'h0);
    chk("unmapped error", err, 1);
    chk("unmapped data", rd, 0);
  endtask
  // watchdog well beyond the roughly 640 cycles the scenarios need
  initial
  begin
    #50000;
    errors++;
    give_verdict();
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_codes();
    t_misc();
    give_verdict();
  end
endmodule
